// ### inc/tvd_pkg.sv
// Constants and carrier types for the text video command and fetch block.
// Assumes a 100 MHz system clock and a host bus seen through pins.
package tvd_pkg;

  localparam int          CLK_MHZ        = 100;
  // I/O decode
  localparam logic [7:0]  IO_TIMING_ADDR = 8'h04;
  localparam logic [7:0]  IO_CTRL_ADDR   = 8'h0C;
  localparam int          TCMD_RATE_BIT  = 5;
  localparam int          TCMD_VAL_BIT   = 4;
  localparam int          CCMD_MSB       = 3;
  // Control unit command codes
  localparam logic [3:0]  CC_SCROLL_HI   = 4'h4;
  localparam logic [3:0]  CC_BLINK       = 4'h8;
  localparam logic [3:0]  CC_VIRQ_CLR    = 4'h9;
  localparam logic [3:0]  CC_REV_ON      = 4'hA;
  localparam logic [3:0]  CC_REV_OFF     = 4'hB;
  // Host memory banks (address bits 19:12)
  localparam logic [7:0]  SCREEN_BANK    = 8'hEE;
  localparam logic [7:0]  ATTR_BANK      = 8'hEF;
  localparam int          RAM_AW         = 12;
  localparam int          VID_AW         = 11;
  // Display geometry
  localparam logic [7:0]  LINE_LEN_80    = 8'h50;
  localparam logic [7:0]  LINE_LEN_132   = 8'h84;
  localparam logic [7:0]  SHOW_80        = 8'h53;
  localparam logic [7:0]  SHOW_132       = 8'h89;
  localparam logic [7:0]  SHOW_DW_80     = 8'h29;
  localparam logic [7:0]  SHOW_DW_132    = 8'h44;
  localparam logic [7:0]  CHARS_80       = 8'h66;
  localparam logic [7:0]  CHARS_132      = 8'hAA;
  localparam logic [7:0]  HSYNC_START    = 8'h5C;
  localparam logic [7:0]  HSYNC_LEN      = 8'h08;
  localparam logic [3:0]  SCAN_LAST      = 4'h9;
  localparam logic [4:0]  TEXT_LINES     = 5'h18;
  localparam logic [8:0]  ACTIVE_SCANS   = 9'h0F0;
  localparam logic [8:0]  SCANS_60       = 9'h106;
  localparam logic [8:0]  SCANS_50       = 9'h138;
  localparam logic [8:0]  VSYNC_START    = 9'h0F8;
  localparam logic [8:0]  VSYNC_LEN      = 9'h003;
  // Character period in ns per column mode, converted to clock cycles
  localparam int          CHAR_NS_80     = 620;
  localparam int          CHAR_NS_132    = 370;
  localparam logic [6:0]  CHAR_DIV_80    = 7'((CHAR_NS_80 * CLK_MHZ) / 1000);
  localparam logic [6:0]  CHAR_DIV_132   = 7'((CHAR_NS_132 * CLK_MHZ) / 1000);
  // Reset values
  localparam logic        COL132_RST     = 1'b0;
  localparam logic        RATE50_RST     = 1'b0;
  localparam logic        ILACE_RST      = 1'b0;
  localparam logic [3:0]  SCROLL_RST     = 4'h0;
  // Fetch buffer
  localparam int          FIFO_DEPTH     = 4;
  localparam int          ATTR_USED      = 4;

  typedef struct packed {
    logic [7:0]           chr;
    logic [ATTR_USED-1:0] attr;
  } tvd_vid_word_s;

  localparam int          VID_W          = $bits(tvd_vid_word_s);

  typedef enum logic [1:0] {
    TVD_FETCH_IDLE,
    TVD_FETCH_ADDR,
    TVD_FETCH_DATA
  } tvd_fetch_e;

endpackage

// ### verilog/tvd_video.sv
// Text video timing unit, control unit and display RAM line fetch.
// Assumes host I/O and memory strobes arrive asynchronously on pins and
// that the display RAMs answer a registered address in the same cycle.
`timescale 1ns/1ps

module tvd_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output      logic             in_ready,
  output      logic             out_valid,
  output      logic [WIDTH-1:0] out_data,
  input  wire logic             out_ready
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready = (count_reg != (PW+1)'(DEPTH));
  assign push     = in_valid && in_ready;
  assign pop      = (count_reg != '0) && (!out_valid || out_ready);

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Registered output stage
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data  <= mem[rd_ptr_reg];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule // tvd_fifo

// Functional notes
// - Timing commands written at I/O 04H use only data bits 5 and 4.
// - Bit 5 low: bit 4 picks 80 (0) or 132 (1) columns.
// - Bit 5 high: bit 4 picks 60 Hz (0) or 50 Hz (1).
// - Column command sets interlace, rate command clears it; last wins.
// - Any timing command write restarts the timing chain.
// - 80-column mode shows 83 single or 41 double-size columns.
// - 132-column mode shows 137 single or 68 double-size columns.
// - Control commands written at I/O 0CH use data bits 3 to 0.
// - Codes 0-3 load scroll latch low bits; high bits kept.
// - Codes 4-7 load scroll latch high bits; low bits kept.
// - Code 9 clears the pending vertical interrupt.
// - Code A sets reverse field; code 8 toggles the blink flip-flop.
// - Code B clears reverse field for normal video.
// - During fetch: own RAMs, hold host waiting, drive 11-bit address.
// - Host owns the RAMs most of the time; fetch takes a small share.
// - Data is fetched a whole display line at a time.
// - Host and fetch share one RAM address multiplexer.
// - Only the four low attribute bits are used.
// - Screen RAM bank starts at EE000H, attribute RAM at EF000H.
// - RAMs hold 24 text lines of 80 or 132 characters.
// - Scroll latch takes effect at the vertical reset of next frame.
// - Scroll value picks only the first scan row of the frame's first text line.
module tvd_video (
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic                      io_wr_b,
  input  wire logic [7:0]                io_addr,
  input  wire logic [7:0]                io_data,
  input  wire logic                      mem_req_b,
  input  wire logic [19:0]               mem_addr,
  output      logic                      host_wait,
  output      logic [tvd_pkg::RAM_AW-1:0] ram_addr,
  output      logic                      ram_screen_sel,
  output      logic                      ram_attr_sel,
  output      logic                      ram_video_own,
  input  wire logic [7:0]                ram_screen_data,
  input  wire logic [7:0]                ram_attr_data,
  output      logic                      vid_valid,
  output      tvd_pkg::tvd_vid_word_s    vid_word,
  input  wire logic                      vid_ready,
  output      logic                      col132,
  output      logic                      rate50,
  output      logic                      interlace,
  output      logic [7:0]                show_cols,
  output      logic [7:0]                show_cols_dw,
  output      logic                      blink,
  output      logic                      reverse_field,
  output      logic [3:0]                scroll_active,
  output      logic [3:0]                scan_row,
  output      logic                      hsync,
  output      logic                      vsync,
  output      logic                      hblank,
  output      logic                      vblank,
  output      logic                      vert_irq
);
  import tvd_pkg::*;

  localparam int          PIN_W    = 38;
  localparam logic [37:0] PIN_INIT = {1'b1, 16'h0000, 1'b1, 20'h00000};

  function automatic logic bank_hit(input logic [19:0] a,
                                    input logic [7:0] bank);
    bank_hit = (a[19:12] == bank);
  endfunction

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_s1;
  logic [PIN_W-1:0] pin_s2;
  logic [PIN_W-1:0] pin_s3;
  logic [PIN_W-1:0] pin_st;
  logic             wr_b_st;
  logic             wr_b_prev_reg;
  logic [7:0]       addr_st;
  logic [7:0]       data_st;
  logic             mreq_b_st;
  logic [19:0]      maddr_st;
  logic             wr_pulse;
  logic             tcmd_wr;
  logic             ccmd_wr;
  logic [3:0]       ccode;
  logic [3:0]       scroll_latch_reg;
  logic [6:0]       div_cnt_reg;
  logic             char_en;
  logic [7:0]       char_cnt_reg;
  logic [8:0]       scan_line_reg;
  logic [4:0]       text_line_reg;
  logic             line_end;
  logic             frame_end;
  logic [7:0]       line_len;
  tvd_fetch_e       fetch_state_reg;
  logic             fetch_due_reg;
  logic [7:0]       fetch_cnt_reg;
  logic [VID_AW-1:0] base_reg;
  logic [VID_AW-1:0] fetch_addr_reg;
  tvd_vid_word_s    fifo_in;
  logic             fifo_push;
  logic             fifo_in_ready;
  logic             host_hit;

  assign pin_raw = {io_wr_b, io_addr, io_data, mem_req_b, mem_addr};

  // Three-stage pin synchroniser; a bit changes once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_sync
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          pin_s1[gi] <= PIN_INIT[gi];
          pin_s2[gi] <= PIN_INIT[gi];
          pin_s3[gi] <= PIN_INIT[gi];
          pin_st[gi] <= PIN_INIT[gi];
        end else begin
          pin_s1[gi] <= pin_raw[gi];
          pin_s2[gi] <= pin_s1[gi];
          pin_s3[gi] <= pin_s2[gi];
          if (pin_s2[gi] == pin_s3[gi]) begin
            pin_st[gi] <= pin_s3[gi];
          end
        end
      end
    end
  endgenerate

  assign {wr_b_st, addr_st, data_st, mreq_b_st, maddr_st} = pin_st;

  // Write strobe edge; reads never reach either command unit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_b_prev_reg <= 1'b1;
    end else begin
      wr_b_prev_reg <= wr_b_st;
    end
  end

  assign wr_pulse = wr_b_prev_reg && !wr_b_st;
  assign tcmd_wr  = wr_pulse && (addr_st == IO_TIMING_ADDR);
  assign ccmd_wr  = wr_pulse && (addr_st == IO_CTRL_ADDR);
  assign ccode    = data_st[CCMD_MSB:0];

  // Timing unit mode bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      col132    <= COL132_RST;
      rate50    <= RATE50_RST;
      interlace <= ILACE_RST;
    end else if (tcmd_wr) begin
      if (!data_st[TCMD_RATE_BIT]) begin
        col132    <= data_st[TCMD_VAL_BIT];
        interlace <= 1'b1;
      end else begin
        rate50    <= data_st[TCMD_VAL_BIT];
        interlace <= 1'b0;
      end
    end
  end

  // Visible column counts per mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      show_cols    <= SHOW_80;
      show_cols_dw <= SHOW_DW_80;
    end else begin
      show_cols    <= col132 ? SHOW_132 : SHOW_80;
      show_cols_dw <= col132 ? SHOW_DW_132 : SHOW_DW_80;
    end
  end

  // Control unit scroll latch and screen attributes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scroll_latch_reg <= SCROLL_RST;
    end else if (ccmd_wr && !ccode[3]) begin
      if (ccode[2] == CC_SCROLL_HI[2]) begin
        scroll_latch_reg[3:2] <= ccode[1:0];
      end else begin
        scroll_latch_reg[1:0] <= ccode[1:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      blink         <= 1'b0;
      reverse_field <= 1'b0;
    end else if (ccmd_wr) begin
      case (ccode)
        CC_BLINK:   blink <= !blink;
        CC_REV_ON:  reverse_field <= 1'b1;
        CC_REV_OFF: reverse_field <= 1'b0;
        default:    blink <= blink;
      endcase
    end
  end

  // Character clock divider
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt_reg <= '0;
    end else if (tcmd_wr || char_en) begin
      div_cnt_reg <= '0;
    end else begin
      div_cnt_reg <= div_cnt_reg + 1'b1;
    end
  end

  assign char_en   = (div_cnt_reg == (col132 ? CHAR_DIV_132 : CHAR_DIV_80)
                      - 7'h01);
  assign line_end  = char_en &&
                     (char_cnt_reg == (col132 ? CHARS_132 : CHARS_80) - 8'h01);
  assign frame_end = line_end &&
                     (scan_line_reg == (rate50 ? SCANS_50 : SCANS_60) - 9'h001);
  assign line_len  = col132 ? LINE_LEN_132 : LINE_LEN_80;

  // Character and scan line counters
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      char_cnt_reg  <= '0;
      scan_line_reg <= '0;
    end else if (tcmd_wr) begin
      char_cnt_reg  <= '0;
      scan_line_reg <= '0;
    end else if (char_en) begin
      char_cnt_reg <= line_end ? 8'h00 : char_cnt_reg + 8'h01;
      if (frame_end) begin
        scan_line_reg <= '0;
      end else if (line_end) begin
        scan_line_reg <= scan_line_reg + 9'h001;
      end
    end
  end

  // Scan row within a text line, started from the frame's scroll value
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scroll_active <= SCROLL_RST;
      scan_row      <= '0;
      text_line_reg <= '0;
    end else if (tcmd_wr) begin
      scan_row      <= scroll_active;
      text_line_reg <= '0;
    end else if (frame_end) begin
      scroll_active <= scroll_latch_reg;
      scan_row      <= (scroll_latch_reg > SCAN_LAST) ? SCAN_LAST
                                                      : scroll_latch_reg;
      text_line_reg <= '0;
    end else if (line_end && !vblank) begin
      if (scan_row >= SCAN_LAST) begin
        scan_row      <= '0;
        text_line_reg <= text_line_reg + 5'h01;
      end else begin
        scan_row <= scan_row + 4'h1;
      end
    end
  end

  // Sync and blanking
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hsync  <= 1'b0;
      vsync  <= 1'b0;
      hblank <= 1'b1;
      vblank <= 1'b0;
    end else begin
      hsync  <= (char_cnt_reg >= HSYNC_START) &&
                (char_cnt_reg < HSYNC_START + HSYNC_LEN);
      vsync  <= (scan_line_reg >= VSYNC_START) &&
                (scan_line_reg < VSYNC_START + VSYNC_LEN);
      hblank <= (char_cnt_reg >= show_cols);
      vblank <= (scan_line_reg >= ACTIVE_SCANS) ||
                (text_line_reg >= TEXT_LINES);
    end
  end

  // Vertical interrupt: set as scan line ACTIVE_SCANS begins, set wins over clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vert_irq <= 1'b0;
    end else if (line_end && (scan_line_reg == ACTIVE_SCANS - 9'h001)) begin
      vert_irq <= 1'b1;
    end else if (ccmd_wr && (ccode == CC_VIRQ_CLR)) begin
      vert_irq <= 1'b0;
    end
  end

  // Line fetch request: first line of a frame or each new text line
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fetch_due_reg <= 1'b0;
    end else if (frame_end ||
                 (line_end && !vblank && (scan_row >= SCAN_LAST) &&
                  (text_line_reg < TEXT_LINES - 5'h01))) begin
      fetch_due_reg <= 1'b1;
    end else if (fetch_state_reg == TVD_FETCH_IDLE) begin
      fetch_due_reg <= 1'b0;
    end
  end

  // Fetch engine: one whole line per request, paced by buffer space
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fetch_state_reg <= TVD_FETCH_IDLE;
      fetch_cnt_reg   <= '0;
      fetch_addr_reg  <= '0;
      base_reg        <= '0;
    end else begin
      case (fetch_state_reg)
        TVD_FETCH_IDLE: begin
          if (frame_end || tcmd_wr) begin
            base_reg <= '0;
          end else if (fetch_due_reg) begin
            fetch_addr_reg  <= base_reg;
            fetch_cnt_reg   <= '0;
            fetch_state_reg <= TVD_FETCH_ADDR;
          end
        end
        TVD_FETCH_ADDR: begin
          fetch_state_reg <= TVD_FETCH_DATA;
        end
        TVD_FETCH_DATA: begin
          if (fifo_in_ready) begin
            fetch_addr_reg <= fetch_addr_reg + 11'h001;
            fetch_cnt_reg  <= fetch_cnt_reg + 8'h01;
            if (fetch_cnt_reg == line_len - 8'h01) begin
              base_reg        <= base_reg + {3'b000, line_len};
              fetch_state_reg <= TVD_FETCH_IDLE;
            end else begin
              fetch_state_reg <= TVD_FETCH_ADDR;
            end
          end
        end
        default: fetch_state_reg <= TVD_FETCH_IDLE;
      endcase
    end
  end

  assign fifo_push     = (fetch_state_reg == TVD_FETCH_DATA);
  assign fifo_in.chr   = ram_screen_data;
  assign fifo_in.attr  = ram_attr_data[ATTR_USED-1:0];
  assign host_hit      = !mreq_b_st &&
                         (bank_hit(maddr_st, SCREEN_BANK) ||
                          bank_hit(maddr_st, ATTR_BANK));

  // Shared RAM address multiplexer and host wait
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ram_addr       <= '0;
      ram_screen_sel <= 1'b0;
      ram_attr_sel   <= 1'b0;
      ram_video_own  <= 1'b0;
      host_wait      <= 1'b0;
    end else if (fetch_state_reg != TVD_FETCH_IDLE) begin
      ram_addr       <= {1'b0, fetch_addr_reg};
      ram_screen_sel <= 1'b1;
      ram_attr_sel   <= 1'b1;
      ram_video_own  <= 1'b1;
      host_wait      <= host_hit;
    end else begin
      ram_addr       <= maddr_st[RAM_AW-1:0];
      ram_screen_sel <= !mreq_b_st && bank_hit(maddr_st, SCREEN_BANK);
      ram_attr_sel   <= !mreq_b_st && bank_hit(maddr_st, ATTR_BANK);
      ram_video_own  <= 1'b0;
      host_wait      <= host_hit && fetch_due_reg;
    end
  end

  tvd_fifo #(
    .WIDTH (VID_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (fifo_push),
    .in_data   (fifo_in),
    .in_ready  (fifo_in_ready),
    .out_valid (vid_valid),
    .out_data  (vid_word),
    .out_ready (vid_ready)
  );
endmodule // tvd_video

// ### tb/tvd_ram_model.sv
// Display RAM pair seen from the fetch side.
// Assumes a registered address; data answers in the same cycle.
`timescale 1ns/1ps

module tvd_ram_model (
  input  wire logic [11:0] ram_addr,
  input  wire logic        ram_screen_sel,
  input  wire logic        ram_attr_sel,
  output      logic [7:0]  ram_screen_data,
  output      logic [7:0]  ram_attr_data
);
  // One address feeds both RAMs; deselected RAM shows inverted junk
  always_comb begin
    ram_screen_data = ram_addr[7:0] ^ 8'h5A;
    if (!ram_screen_sel) ram_screen_data = ~ram_screen_data;
  end
  // Upper attribute nibble is nonzero so that leaking it shows up
  always_comb begin
    ram_attr_data = {4'hF, ram_addr[3:0]};
    if (!ram_attr_sel) ram_attr_data = ~ram_attr_data;
  end
endmodule // tvd_ram_model

// ### tb/tvd_video_monitor.sv
// Port checks for the text video block.
// Assumes I/O address and data stay put around each strobe.
`timescale 1ns/1ps

module tvd_video_monitor
  import tvd_pkg::*;
(
  input wire logic          clk,
  input wire logic          rst_b,
  input wire logic [7:0]    io_addr,
  input wire logic [7:0]    io_data,
  input wire logic [11:0]   ram_addr,
  input wire logic          ram_video_own,
  input wire logic          vid_valid,
  input wire tvd_vid_word_s vid_word,
  input wire logic          vid_ready,
  input wire logic          col132,
  input wire logic          rate50,
  input wire logic          interlace,
  input wire logic [7:0]    show_cols,
  input wire logic [7:0]    show_cols_dw,
  input wire logic          blink,
  input wire logic          reverse_field,
  input wire logic          vert_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  a_col_mode: assert property ($changed(col132) |->
    $past(io_addr) == IO_TIMING_ADDR && !$past(io_data[5])
    && col132 == $past(io_data[4])) else $error("column mode change");
  a_rate_mode: assert property ($changed(rate50) |->
    $past(io_addr) == IO_TIMING_ADDR && $past(io_data[5])
    && rate50 == $past(io_data[4])) else $error("rate change");
  a_ilace_order: assert property ($changed(interlace) |->
    $past(io_addr) == IO_TIMING_ADDR
    && interlace == !$past(io_data[5])) else $error("interlace change");
  a_show_single: assert property (
    show_cols == ($past(col132) ? SHOW_132 : SHOW_80))
    else $error("single width columns");
  a_show_double: assert property (
    show_cols_dw == ($past(col132) ? SHOW_DW_132 : SHOW_DW_80))
    else $error("double width columns");
  a_blink_flip: assert property ($changed(blink) |->
    $past(io_addr) == IO_CTRL_ADDR && $past(io_data[3:0]) == CC_BLINK)
    else $error("blink change");
  a_rev_on: assert property ($rose(reverse_field) |->
    $past(io_addr) == IO_CTRL_ADDR && $past(io_data[3:0]) == CC_REV_ON)
    else $error("reverse set");
  a_rev_off: assert property ($fell(reverse_field) |->
    $past(io_addr) == IO_CTRL_ADDR && $past(io_data[3:0]) == CC_REV_OFF)
    else $error("reverse clear");
  a_irq_clear: assert property ($fell(vert_irq) |->
    $past(io_addr) == IO_CTRL_ADDR
    && $past(io_data[3:0]) == CC_VIRQ_CLR) else $error("irq clear");
  a_fetch_addr: assert property (ram_video_own |->
    !ram_addr[11]) else $error("fetch address wider than 11 bits");
  a_vid_hold: assert property (vid_valid && !vid_ready |=>
    vid_valid && $stable(vid_word)) else $error("stream word dropped");
endmodule // tvd_video_monitor

bind tvd_video tvd_video_monitor mon (.clk(clk), .rst_b(rst_b),
  .io_addr(io_addr), .io_data(io_data), .ram_addr(ram_addr),
  .ram_video_own(ram_video_own), .vid_valid(vid_valid),
  .vid_word(vid_word), .vid_ready(vid_ready), .col132(col132),
  .rate50(rate50), .interlace(interlace), .show_cols(show_cols),
  .show_cols_dw(show_cols_dw), .blink(blink),
  .reverse_field(reverse_field), .vert_irq(vert_irq));

// ### tb/text_video_command_and_dma_test.sv
// Self-checking bench for the text video block.
// Assumes a 100 MHz clock and inputs driven at the falling edge.
`timescale 1ns/1ps

module text_video_command_and_dma_test;
  import tvd_pkg::*;
  logic clk = 0, rst_b = 0, io_wr_b = 1, mem_req_b = 1, vid_ready = 1;
  logic [7:0]    io_addr = 8'hFF, io_data = 8'h00, show_cols, show_cols_dw;
  logic [19:0]   mem_addr = 20'h00000;
  logic [11:0]   ram_addr;
  logic [7:0]    ram_screen_data, ram_attr_data;
  logic [3:0]    scroll_active, scan_row;
  logic          host_wait, ram_screen_sel, ram_attr_sel, ram_video_own;
  logic          vid_valid, col132, rate50, interlace, blink;
  logic          reverse_field, hsync, vsync, hblank, vblank, vert_irq;
  tvd_vid_word_s vid_word;
  int            n_mismatch = 0, checked = 0, cycles = 0;

  always #5 clk = ~clk;

  tvd_video dut (.clk(clk), .rst_b(rst_b), .io_wr_b(io_wr_b),
    .io_addr(io_addr), .io_data(io_data), .mem_req_b(mem_req_b),
    .mem_addr(mem_addr), .host_wait(host_wait), .ram_addr(ram_addr),
    .ram_screen_sel(ram_screen_sel), .ram_attr_sel(ram_attr_sel),
    .ram_video_own(ram_video_own), .ram_screen_data(ram_screen_data),
    .ram_attr_data(ram_attr_data), .vid_valid(vid_valid),
    .vid_word(vid_word), .vid_ready(vid_ready), .col132(col132),
    .rate50(rate50), .interlace(interlace), .show_cols(show_cols),
    .show_cols_dw(show_cols_dw), .blink(blink),
    .reverse_field(reverse_field), .scroll_active(scroll_active),
    .scan_row(scan_row), .hsync(hsync), .vsync(vsync), .hblank(hblank),
    .vblank(vblank), .vert_irq(vert_irq));

  tvd_ram_model ram (.ram_addr(ram_addr), .ram_screen_sel(ram_screen_sel),
    .ram_attr_sel(ram_attr_sel), .ram_screen_data(ram_screen_data),
    .ram_attr_data(ram_attr_data));

  task automatic end_sim;
    if (n_mismatch == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h not %h", $time, what, got, exp);
    end
  endtask

  // Strobe timing kept inside the synchroniser's needs
  task automatic io_wr(input logic [7:0] a, d);
    @(negedge clk);
    io_addr = a;
    io_data = d;
    repeat (6) @(negedge clk);
    io_wr_b = 0;
    repeat (5) @(negedge clk);
    io_wr_b = 1;
    repeat (8) @(negedge clk);
  endtask

  task automatic t_reset;
    chk(8'(col132), 8'h00, "col132");
    chk(8'(rate50), 8'h00, "rate50");
    chk(8'(interlace), 8'h00, "interlace");
    chk(show_cols, 8'h53, "show_cols");
    chk(show_cols_dw, 8'h29, "show_cols_dw");
    chk(8'({blink, reverse_field, vert_irq}), 8'h00, "attr");
    chk(8'(scroll_active), 8'h00, "scroll");
  endtask

  // All four timing codes, junk in the bits outside the field
  task automatic t_timing;
    logic [7:0] cmd [4] = '{8'h95, 8'hB5, 8'hA5, 8'h85};
    logic       c, r, il;
    c = 0;
    r = 0;
    il = 0;
    foreach (cmd[i]) begin
      io_wr(IO_TIMING_ADDR, cmd[i]);
      if (cmd[i][5]) begin
        r = cmd[i][4];
        il = 0;
      end else begin
        c = cmd[i][4];
        il = 1;
      end
      chk(8'(col132), 8'(c), "col132");
      chk(8'(rate50), 8'(r), "rate50");
      chk(8'(interlace), 8'(il), "interlace");
      chk(show_cols, c ? 8'h89 : 8'h53, "show_cols");
      chk(show_cols_dw, c ? 8'h44 : 8'h29, "show_cols_dw");
    end
  endtask

  task automatic t_control;
    io_wr(IO_CTRL_ADDR, 8'hF8);
    chk(8'(blink), 8'h01, "blink");
    io_wr(IO_CTRL_ADDR, 8'h08);
    chk(8'(blink), 8'h00, "blink");
    io_wr(8'h08, 8'h0A);
    chk(8'(reverse_field), 8'h00, "wrong port");
    io_wr(IO_CTRL_ADDR, 8'h0A);
    chk(8'(reverse_field), 8'h01, "reverse on");
    for (int k = 12; k < 16; k++)
      io_wr(IO_CTRL_ADDR, 8'(k));
    chk(8'({blink, reverse_field}), 8'h01, "unused codes");
    io_wr(IO_CTRL_ADDR, 8'h0B);
    chk(8'(reverse_field), 8'h00, "reverse off");
    io_wr(IO_CTRL_ADDR, 8'h09);
    chk(8'(vert_irq), 8'h00, "irq");
    io_wr(IO_CTRL_ADDR, 8'h13);
    io_wr(IO_CTRL_ADDR, 8'h06);
    chk(8'(scroll_active), 8'h00, "latch early");
    chk(8'(col132), 8'h00, "timing kept");
  endtask

  // First line fetch: host held off the banks, words paired and in order
  task automatic t_fetch;
    logic [7:0] k;
    int         w;
    k = 8'h00;
    w = 0;
    @(negedge clk);
    mem_addr = 20'hEE010;
    mem_req_b = 0;
    while (!ram_video_own && w < 70000) begin
      @(negedge clk);
      w++;
    end
    chk(8'(host_wait), 8'h01, "host_wait");
    while (k < 8'h50 && w < 75000) begin
      @(negedge clk);
      vid_ready = w[1];
      w++;
      if (vid_valid && vid_ready) begin
        chk(vid_word.chr, k ^ 8'h5A, "chr");
        chk(8'(vid_word.attr), 8'(k[3:0]), "attr");
        k++;
      end
    end
    vid_ready = 1;
    mem_req_b = 1;
    chk(k, 8'h50, "line words");
  endtask

  // A host access outside the display banks is never held
  task automatic t_host;
    @(negedge clk);
    mem_addr = 20'h12345;
    mem_req_b = 0;
    repeat (10) begin
      @(negedge clk);
      chk(8'(host_wait), 8'h00, "host_wait");
    end
    mem_req_b = 1;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      n_mismatch++;
      $display("unexpected at %0t: run too long", $time);
      end_sim();
    end
  end

  initial begin
    repeat (16) @(negedge clk);
    rst_b = 1;
    repeat (2) @(negedge clk);
    t_reset();
    t_timing();
    t_control();
    t_host();
    t_fetch();
    end_sim();
  end
endmodule // text_video_command_and_dma_test
